// ==== verilog/icpm_pkg.sv ====
// Constants for the serial control slave and power mode block.
// Assumes a 200 MHz system clock; the serial lines are asynchronous to it.
package icpm_pkg;
  localparam logic [6:0]  ICPM_DEV_ADDR  = 7'h1C;
  localparam logic [7:0]  ICPM_SUB_GLB   = 8'h01;
  localparam logic [7:0]  ICPM_SUB_AGC   = 8'h2F;
  localparam logic [7:0]  ICPM_SUB_WIDE  = 8'h7C;
  localparam logic [7:0]  ICPM_SUB_STAT  = 8'h7E;
  localparam int          ICPM_DEC_BIT   = 7;
  localparam int          ICPM_AUD_BIT   = 4;
  localparam int          ICPM_SRC_LSB   = 2;
  localparam int          ICPM_AGC_W     = 5;
  localparam logic [7:0]  ICPM_GLB_RST   = 8'h00;
  localparam logic [4:0]  ICPM_AGC_RST   = 5'h00;
  localparam logic [4:0]  ICPM_AGC_DEF   = 5'h16;
  localparam logic [15:0] ICPM_WIDE_RST  = 16'h0000;
  localparam logic [15:0] ICPM_WIDE_DEF  = 16'h0000;
  localparam int          ICPM_CLK_PS    = 5000;
  localparam int          ICPM_STRETCH_NS = 20;
  localparam int          ICPM_STRETCH_CYC =
    (ICPM_STRETCH_NS * 1000 + ICPM_CLK_PS - 1) / ICPM_CLK_PS;
  typedef enum logic [3:0] {
    ICPM_IDLE = 4'h0, ICPM_ADDR = 4'h1, ICPM_AACK = 4'h3, ICPM_SUB  = 4'h2,
    ICPM_SACK = 4'h6, ICPM_WDAT = 4'h7, ICPM_WACK = 4'h5, ICPM_RDAT = 4'h4,
    ICPM_RACK = 4'hC
  } icpm_state_t;
endpackage : icpm_pkg

// ==== verilog/icpm_line_if.sv ====
// Synchronised serial line events passed from the line sampler to the slave.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface icpm_line_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_s;
  logic start_c;
  logic stop_c;
  logic pup_s;
  logic pup_rise;
  modport src (output scl_rise, scl_fall, sda_s, start_c, stop_c, pup_s, pup_rise);
  modport dst (input  scl_rise, scl_fall, sda_s, start_c, stop_c, pup_s, pup_rise);
endinterface : icpm_line_if
`default_nettype wire

// ==== verilog/icpm_line_sync.sv ====
// Two-stage synchronisers for the serial lines and power-up pin, plus edge
// and bus condition detection. Inputs are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module icpm_line_sync (
  input  wire logic  clk,
  input  wire logic  resetn,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  input  wire logic  pup_i,
  icpm_line_if.src   ev
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [2:0] prev_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 3'h3;
      sync_r <= 3'h3;
      prev_r <= 3'h3;
    end else begin
      meta_r <= {pup_i, sda_i, scl_i};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Bit 2 (power-up) resets low so a high pin at release reads as a rising edge
  assign ev.scl_rise = sync_r[0] & ~prev_r[0];
  assign ev.scl_fall = ~sync_r[0] & prev_r[0];
  assign ev.sda_s    = sync_r[1];
  assign ev.start_c  = sync_r[0] & prev_r[0] & ~sync_r[1] & prev_r[1];
  assign ev.stop_c   = sync_r[0] & prev_r[0] & sync_r[1] & ~prev_r[1];
  assign ev.pup_s    = sync_r[2] & prev_r[2];
  assign ev.pup_rise = sync_r[2] & ~prev_r[2];
endmodule : icpm_line_sync
`default_nettype wire

// ==== verilog/icpm_ctrl.sv ====
// Serial control slave with global configuration and power mode outputs.
// Assumes open-drain lines resolved outside; clk at 200 MHz, resetn async.
// What this block does
// - Serial slave; first byte after address selects the internal register.
// - Answers seven-bit address 0011100: 38h write, 39h read.
// - May hold the serial clock low to gain time.
// - Wide registers move as two acknowledged bytes, high byte first.
// - Hardware reset clears every control register to zero.
// - Power-up rising edge or power-on loads documented defaults.
// - Registers are write-only, read/write, or read-only status.
// - Decoder enable set runs decoding and drives its output pin.
// - Decoder enable clear gives standby and forces its pin low.
// - Audio power clear puts the audio path into low-current state.
// - Power-up pin low puts the whole device into zero power.
// - Config bit 7 decoder enable, bit 4 audio power, bits 3:2 source.
`timescale 1ns/1ps
`default_nettype none
module icpm_ctrl #(
  parameter int STRETCH_CYC = icpm_pkg::ICPM_STRETCH_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       scl_i,
  output var  logic       scl_o,
  output var  logic       scl_oe_n,
  input  wire logic       sda_i,
  output var  logic       sda_o,
  output var  logic       sda_oe_n,
  input  wire logic       power_up_pin,
  output var  logic       decoder_enable,
  output var  logic       digital_standby,
  output var  logic       audio_power_on,
  output var  logic [1:0] audio_source_select,
  output var  logic       zero_power
);
  import icpm_pkg::*;

  // The stretch counter is eight bits and the hold must outlast one sync delay
  if (STRETCH_CYC < 2 || STRETCH_CYC > 255) begin : g_bad_stretch
    $error("STRETCH_CYC out of range");
  end

  icpm_line_if ev ();
  icpm_line_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .scl_i  (scl_i),
    .sda_i  (sda_i),
    .pup_i  (power_up_pin),
    .ev     (ev)
  );

  icpm_state_t st_r;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic [2:0]  cnt_r;
  logic        got8_r;
  logic        rw_r;
  logic        nack_r;
  logic [7:0]  sub_r;
  logic [1:0]  idx_r;
  logic [7:0]  hi_hold_r;
  logic [7:0]  stretch_r;
  logic [7:0]  glb_r;
  logic [4:0]  agc_r;
  logic [15:0] wide_r;

  // Read data by subaddress and byte index; write-only and unmapped read zero
  function automatic logic [7:0] rd_byte(input logic [7:0] sub, input logic [1:0] idx,
                                         input logic [4:0] agc, input logic [15:0] wide,
                                         input logic [15:0] stat);
    logic [7:0] v;
    v = 8'h00;
    if (sub == ICPM_SUB_AGC && idx == 2'h0) v = {3'h0, agc};
    if (sub == ICPM_SUB_WIDE && idx == 2'h0) v = wide[15:8];
    if (sub == ICPM_SUB_WIDE && idx == 2'h1) v = wide[7:0];
    if (sub == ICPM_SUB_STAT && idx == 2'h0) v = stat[15:8];
    if (sub == ICPM_SUB_STAT && idx == 2'h1) v = stat[7:0];
    return v;
  endfunction : rd_byte

  wire        byte_end  = ev.scl_fall & got8_r;
  wire        addr_hit  = shift_r[7:1] == ICPM_DEV_ADDR;
  wire [15:0] status_w  = {12'h000, st_r != ICPM_IDLE, decoder_enable,
                           audio_power_on, digital_standby};
  wire [1:0]  idx_nxt   = (idx_r == 2'h3) ? idx_r : idx_r + 2'h1;
  wire [7:0]  rd_first  = rd_byte(sub_r, 2'h0, agc_r, wide_r, status_w);
  wire [7:0]  rd_next   = rd_byte(sub_r, idx_nxt, agc_r, wide_r, status_w);
  wire        wr_strobe = st_r == ICPM_WDAT && byte_end;
  wire        wr_glb    = wr_strobe && sub_r == ICPM_SUB_GLB && idx_r == 2'h0;
  wire        wr_agc    = wr_strobe && sub_r == ICPM_SUB_AGC && idx_r == 2'h0;
  wire        wr_wide   = wr_strobe && sub_r == ICPM_SUB_WIDE && idx_r == 2'h1;

  // Serial slave sequencing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r      <= ICPM_IDLE;
      shift_r   <= 8'h00;
      tx_r      <= 8'hFF;
      cnt_r     <= 3'h0;
      got8_r    <= 1'b0;
      rw_r      <= 1'b0;
      nack_r    <= 1'b0;
      sub_r     <= 8'h00;
      idx_r     <= 2'h0;
      hi_hold_r <= 8'h00;
      stretch_r <= 8'h00;
      sda_oe_n  <= 1'b1;
    end else if (!ev.pup_s) begin
      st_r      <= ICPM_IDLE;
      got8_r    <= 1'b0;
      stretch_r <= 8'h00;
      sda_oe_n  <= 1'b1;
    end else if (ev.start_c) begin
      st_r     <= ICPM_ADDR;
      cnt_r    <= 3'h0;
      got8_r   <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (ev.stop_c) begin
      st_r     <= ICPM_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      if (stretch_r != 8'h00) stretch_r <= stretch_r - 8'h01;
      if (ev.scl_rise && (st_r == ICPM_ADDR || st_r == ICPM_SUB || st_r == ICPM_WDAT)) begin
        shift_r <= {shift_r[6:0], ev.sda_s};
        cnt_r   <= cnt_r + 3'h1;
        got8_r  <= cnt_r == 3'h7;
      end
      if (ev.scl_rise && st_r == ICPM_RACK) nack_r <= ev.sda_s;
      case (st_r)
        ICPM_ADDR: if (byte_end) begin
          got8_r   <= 1'b0;
          rw_r     <= shift_r[0];
          st_r     <= addr_hit ? ICPM_AACK : ICPM_IDLE;
          sda_oe_n <= ~addr_hit;
        end
        ICPM_AACK: if (ev.scl_fall) begin
          idx_r <= 2'h0;
          if (rw_r) begin
            st_r      <= ICPM_RDAT;
            tx_r      <= {rd_first[6:0], 1'b1};
            sda_oe_n  <= rd_first[7];
            stretch_r <= 8'(STRETCH_CYC);
          end else begin
            st_r     <= ICPM_SUB;
            sda_oe_n <= 1'b1;
          end
        end
        ICPM_SUB: if (byte_end) begin
          got8_r   <= 1'b0;
          sub_r    <= shift_r;
          idx_r    <= 2'h0;
          st_r     <= ICPM_SACK;
          sda_oe_n <= 1'b0;
        end
        ICPM_SACK, ICPM_WACK: if (ev.scl_fall) begin
          st_r     <= ICPM_WDAT;
          sda_oe_n <= 1'b1;
        end
        ICPM_WDAT: if (byte_end) begin
          got8_r <= 1'b0;
          if (idx_r == 2'h0) hi_hold_r <= shift_r;
          idx_r    <= idx_nxt;
          st_r     <= ICPM_WACK;
          sda_oe_n <= 1'b0;
        end
        ICPM_RDAT: if (ev.scl_fall) begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'h7) begin
            st_r     <= ICPM_RACK;
            sda_oe_n <= 1'b1;
          end else begin
            tx_r     <= {tx_r[6:0], 1'b1};
            sda_oe_n <= tx_r[7];
          end
        end
        ICPM_RACK: if (ev.scl_fall) begin
          cnt_r <= 3'h0;
          if (nack_r) begin
            st_r <= ICPM_IDLE;
          end else begin
            st_r      <= ICPM_RDAT;
            idx_r     <= idx_nxt;
            tx_r      <= {rd_next[6:0], 1'b1};
            sda_oe_n  <= rd_next[7];
            stretch_r <= 8'(STRETCH_CYC);
          end
        end
        default: ;
      endcase
    end
  end

  // Control registers; status is never stored, so writes to it fall away
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      glb_r  <= ICPM_GLB_RST;
      agc_r  <= ICPM_AGC_RST;
      wide_r <= ICPM_WIDE_RST;
    end else if (ev.pup_rise) begin
      glb_r  <= ICPM_GLB_RST;
      agc_r  <= ICPM_AGC_DEF;
      wide_r <= ICPM_WIDE_DEF;
    end else begin
      if (wr_glb) glb_r <= shift_r;
      if (wr_agc) agc_r <= shift_r[ICPM_AGC_W-1:0];
      if (wr_wide) wide_r <= {hi_hold_r, shift_r};
    end
  end

  // Mode outputs, gated by the power-up pin except audio_source_select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      decoder_enable      <= 1'b0;
      digital_standby     <= 1'b1;
      audio_power_on      <= 1'b0;
      audio_source_select <= 2'h0;
      zero_power          <= 1'b1;
      scl_oe_n            <= 1'b1;
      scl_o               <= 1'b0;
      sda_o               <= 1'b0;
    end else begin
      decoder_enable      <= ev.pup_s & glb_r[ICPM_DEC_BIT];
      digital_standby     <= ~(ev.pup_s & glb_r[ICPM_DEC_BIT]);
      audio_power_on      <= ev.pup_s & glb_r[ICPM_AUD_BIT];
      audio_source_select <= glb_r[ICPM_SRC_LSB +: 2];
      zero_power          <= ~ev.pup_s;
      scl_oe_n            <= ~(ev.pup_s && stretch_r != 8'h00);
      scl_o               <= 1'b0;
      sda_o               <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_addr_done;
    ev.pup_s && !ev.start_c && !ev.stop_c && st_r == ICPM_ADDR && byte_end;
  endsequence

  a_addr_ack_hit: assert property (s_addr_done and addr_hit |=> st_r == ICPM_AACK && !sda_oe_n)
    else $error("matching address not acknowledged");
  a_addr_ack_miss: assert property (s_addr_done and !addr_hit |=> st_r == ICPM_IDLE && sda_oe_n)
    else $error("foreign address acknowledged");
  a_sub_capture: assert property (ev.pup_s && !ev.start_c && !ev.stop_c && st_r == ICPM_SUB && byte_end |=> sub_r == $past(shift_r))
    else $error("subaddress not captured");
  sequence s_read_turn;
    ev.pup_s && !ev.start_c && !ev.stop_c && st_r == ICPM_AACK && ev.scl_fall && rw_r;
  endsequence

  a_stretch_hold: assert property (s_read_turn ##1 ev.pup_s ##1 ev.pup_s |-> !scl_oe_n ##1 !scl_oe_n)
    else $error("clock not held before read data");
  a_wide_pair: assert property (wr_wide && ev.pup_s && !ev.start_c && !ev.stop_c && !ev.pup_rise |=> wide_r == {$past(hi_hold_r), $past(shift_r)})
    else $error("wide register not written as high then low");
  a_defaults_load: assert property (ev.pup_rise |=> agc_r == ICPM_AGC_DEF && glb_r == ICPM_GLB_RST)
    else $error("defaults not loaded on power-up edge");
  a_decoder_on: assert property (ev.pup_s && glb_r[ICPM_DEC_BIT] |=> decoder_enable && !digital_standby)
    else $error("decoder enable not driven");
  a_decoder_off: assert property (!glb_r[ICPM_DEC_BIT] |=> !decoder_enable && digital_standby)
    else $error("decoder pin not forced low");
  a_audio_off: assert property (!glb_r[ICPM_AUD_BIT] |=> !audio_power_on)
    else $error("audio power not dropped");
  a_zero_power: assert property (!ev.pup_s |=> zero_power && !decoder_enable && !audio_power_on ##1 sda_oe_n && scl_oe_n)
    else $error("zero power not entered");
endmodule : icpm_ctrl
`default_nettype wire

// ==== verif/icpm_master.sv ====
// Serial bus controller model that drives the slave's clock and data lines.
// Assumes open-drain lines with pull-ups resolved by the bench; clk at 200 MHz.
`timescale 1ns/1ps
`default_nettype none
module icpm_master (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output var  logic m_scl,
  output var  logic m_sda
);
  localparam int HALF = 8;
  event       got;
  logic [7:0] rx;
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // High phase starts only once the slave lets the clock go
  task automatic bit_io(input logic bo, output logic bi);
    int i;
    wt(3);
    m_sda <= bo;
    wt(HALF - 3);
    m_scl <= 1'b1;
    wt(1);
    i = 0;
    while (scl !== 1'b1 && i < 1000) begin
      wt(1);
      i++;
    end
    wt(HALF - 1);
    bi = sda;
    m_scl <= 1'b0;
  endtask : bit_io
  // Also serves as repeated start when the clock is low
  task automatic start();
    wt(3);
    m_sda <= 1'b1;
    wt(5);
    m_scl <= 1'b1;
    wt(HALF);
    m_sda <= 1'b0;
    wt(HALF);
    m_scl <= 1'b0;
  endtask : start
  task automatic stop();
    wt(3);
    m_sda <= 1'b0;
    wt(5);
    m_scl <= 1'b1;
    wt(HALF);
    m_sda <= 1'b1;
    wt(HALF);
  endtask : stop
  task automatic xmit(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_io(d[i], b);
    bit_io(1'b1, ack);
  endtask : xmit
  task automatic recv(input logic nack);
    logic [7:0] d;
    logic       b;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    rx = d;
    ->got;
    bit_io(nack, b);
  endtask : recv
endmodule : icpm_master
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the serial control slave and power mode outputs.
// Assumes icpm_pkg and the design compiled first; controller model is icpm_master.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import icpm_pkg::*;
  logic        clk = 1'b0;
  logic        resetn;
  logic        power_up_pin;
  logic        scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda;
  logic        dec, stby, aud, zp;
  logic [1:0]  src;
  wire  logic  scl;
  wire  logic  sda;
  int          n_fail = 0;
  int          compares = 0;
  logic [7:0]  exp_q[$];
  logic [31:0] seed = 32'h5C8A4C90;
  logic [7:0]  v;
  logic [15:0] w;
  logic        a;
  logic [7:0]  u;
  assign scl = m_scl & (scl_oe_n | scl_o);
  assign sda = m_sda & (sda_oe_n | sda_o);
  always #2.5 clk = ~clk;
  icpm_ctrl #(.STRETCH_CYC(12)) dut (.clk(clk), .resetn(resetn), .scl_i(scl), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .power_up_pin(power_up_pin), .decoder_enable(dec), .digital_standby(stby),
    .audio_power_on(aud), .audio_source_select(src), .zero_power(zp));
  icpm_master m (.clk(clk), .scl(scl), .sda(sda), .m_scl(m_scl), .m_sda(m_sda));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic pins(input logic [7:0] e);
    chk("pins", e, {dec, stby, aud, src, zp, 2'b00});
  endtask : pins
  task automatic wr(input logic [7:0] sub, input logic [23:0] d, input int n);
    m.start();
    m.xmit(8'h38, a);
    chk("ack_adr", 8'h00, {7'h00, a});
    m.xmit(sub, a);
    chk("ack_sub", 8'h00, {7'h00, a});
    for (int i = 0; i < n; i++) begin
      m.xmit(d[23-8*i -: 8], a);
      chk("ack_dat", 8'h00, {7'h00, a});
    end
    m.stop();
  endtask : wr
  task automatic rd(input logic [7:0] sub, input int n);
    m.start();
    m.xmit(8'h38, a);
    m.xmit(sub, a);
    m.start();
    m.xmit(8'h39, a);
    chk("ack_rd", 8'h00, {7'h00, a});
    for (int i = 0; i < n; i++) m.recv(i == n - 1);
    m.stop();
  endtask : rd
  always @(m.got) chk("rd_data", exp_q.pop_front(), m.rx);
  task automatic wrap_up();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    resetn = 1'b0;
    power_up_pin = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    pins(8'h44);
    power_up_pin <= 1'b1;
    repeat (10) @(posedge clk);
    pins(8'h40);
    exp_q.push_back(8'h16);
    rd(8'h2F, 1);
    for (int k = 0; k < 5; k++) begin
      v = (k == 0) ? 8'h90 : 8'(rnd());
      wr(8'h01, {v, 16'h0000}, 1);
      pins({v[7], ~v[7], v[4], v[3:2], 3'b000});
    end
    exp_q.push_back(8'h00);
    rd(8'h01, 1);
    exp_q.push_back(8'h00);
    rd(8'h55, 1);
    w = 16'(rnd());
    wr(8'h7C, {w, 8'hA5}, 3);
    exp_q.push_back(w[15:8]);
    exp_q.push_back(w[7:0]);
    rd(8'h7C, 2);
    u = 8'(rnd());
    wr(8'h7C, {u, 16'h0000}, 1);
    exp_q.push_back(w[15:8]);
    exp_q.push_back(w[7:0]);
    rd(8'h7C, 2);
    wr(8'h7E, {8'(rnd()), 8'(rnd()), 8'h00}, 2);
    exp_q.push_back(8'h00);
    exp_q.push_back({4'h0, 1'b1, v[7], v[4], ~v[7]});
    rd(8'h7E, 2);
    m.start();
    u = 8'(rnd());
    if (u[7:1] == ICPM_DEV_ADDR) u[1] = ~u[1];
    m.xmit(u, a);
    chk("ack_wrong", 8'h01, {7'h00, a});
    m.stop();
    u = 8'(rnd());
    wr(8'h2F, {u, 16'h0000}, 1);
    exp_q.push_back({3'h0, u[4:0]});
    rd(8'h2F, 1);
    wr(8'h01, {8'h80, 16'h0000}, 1);
    pins(8'h80);
    power_up_pin <= 1'b0;
    repeat (10) @(posedge clk);
    pins(8'h44);
    m.start();
    m.xmit(8'h38, a);
    chk("ack_off", 8'h01, {7'h00, a});
    m.stop();
    power_up_pin <= 1'b1;
    repeat (10) @(posedge clk);
    pins(8'h40);
    exp_q.push_back(8'h16);
    rd(8'h2F, 1);
    wr(8'h7C, {16'h1234, 8'h00}, 2);
    wr(8'h01, {8'h90, 16'h0000}, 1);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    pins(8'h44);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    rd(8'h7C, 2);
    chk("pending", 8'h00, 8'(exp_q.size()));
    wrap_up();
  end
endmodule : tb
`default_nettype wire
